// ===== verilog/flash_regs_pkg.sv
// Constants and types shared by the flash divider and security registers.
package flash_regs_pkg;

  // ----------------------------------------------------------------------
  // Register map and widths
  // ----------------------------------------------------------------------
  localparam int        BUS_AW        = 8;
  localparam int        BUS_DW        = 8;
  localparam logic [7:0] OFS_CLK_DIV  = 8'h00;
  localparam logic [7:0] OFS_SECURITY = 8'h01;
  localparam logic [7:0] OFS_CMD_IDX  = 8'h02;
  localparam int        DIV_W         = 6;
  localparam int        IDX_W         = 3;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int LOADED_BIT = 7;
  localparam int LOCK_BIT   = 6;
  localparam int KEY_MSB    = 7;
  localparam int KEY_LSB    = 6;
  localparam int SEC_MSB    = 1;
  localparam int SEC_LSB    = 0;

  // ----------------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0]       KEY_ENABLED   = 2'h2;
  localparam logic [1:0]       SEC_UNSECURED = 2'h2;
  localparam logic [7:0]       SEC_FAULT_VAL = 8'hff;
  localparam logic [7:0]       SEC_RESET_VAL = 8'hff;
  localparam logic [DIV_W-1:0] DIV_RESET     = 6'h00;
  localparam logic [7:0]       ZERO_BYTE     = 8'h00;

  // Reset sequence of the security register, Gray coded.
  typedef enum logic [1:0] {
    SEQ_FETCH = 2'h0,
    SEQ_READY = 2'h1
  } seq_state_t;

endpackage

// ===== verilog/tick_divider.sv
// Programmable divider that turns the bus clock into a timebase tick.
`timescale 1ns/100ps
module tick_divider #(
  parameter int CNT_W = 6
) (
  // Clock and reset.
  input  wire logic             core_clk_in,
  input  wire logic             arst_n_in,
  // Control.
  input  wire logic             run_in,
  input  wire logic [CNT_W-1:0] div_in,
  // Timebase.
  output logic                  tick_out
);
  import flash_regs_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } div_state_t;

  div_state_t state_r;
  div_state_t state_nxt;

  // Count 0..div and tick on the wrap; the >= compare recovers at once
  // if the divide value is lowered in the middle of a period.
  always_comb begin
    state_nxt      = state_r;
    state_nxt.tick = 1'b0;
    if (!run_in) begin
      state_nxt.cnt = '0;
    end else if (state_r.cnt >= div_in) begin
      state_nxt.cnt  = '0;
      state_nxt.tick = 1'b1;
    end else begin
      state_nxt.cnt = CNT_W'(state_r.cnt + 1'b1);
    end
  end

  // State register.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign tick_out = state_r.tick;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);

  chk_tick_on_wrap: assert property (
    run_in && (state_r.cnt >= div_in) |=> tick_out && (state_r.cnt == '0))
    else $error("tick missing at end of divide period");

  chk_tick_idle: assert property (
    !run_in |=> !tick_out)
    else $error("tick while divider stopped");

endmodule // tick_divider

// ===== verilog/flash_regs.sv
// Flash clock divider, security and command index registers.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module flash_regs #(
  parameter int IDX_BITS = flash_regs_pkg::IDX_W
) (
  // Clock and reset.
  input  wire logic                              core_clk_in,
  input  wire logic                              arst_n_in,
  // Register port.
  input  wire logic [flash_regs_pkg::BUS_AW-1:0] addr_in,
  input  wire logic [flash_regs_pkg::BUS_DW-1:0] wdata_in,
  input  wire logic                              wr_in,
  input  wire logic                              rd_in,
  output logic      [flash_regs_pkg::BUS_DW-1:0] rdata_out,
  // Mode and security sources.
  input  wire logic                              special_mode_in,
  input  wire logic                              sec_load_in,
  input  wire logic [7:0]                        sec_byte_in,
  input  wire logic                              sec_dbl_fault_in,
  input  wire logic                              backdoor_unsecure_in,
  // Status and timebase.
  output logic                                   sec_fetch_req_out,
  output logic                                   tick_1mhz_out,
  output logic      [flash_regs_pkg::DIV_W-1:0]  divide_value_out,
  output logic                                   divider_loaded_out,
  output logic                                   backdoor_key_enabled_out,
  output logic                                   unsecured_out,
  output logic      [IDX_BITS-1:0]               command_index_out
);
  import flash_regs_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    seq_state_t          seq;
    logic                loaded;
    logic                lock;
    logic [DIV_W-1:0]    div;
    logic [7:0]          sec;
    logic [IDX_BITS-1:0] idx;
    logic [BUS_DW-1:0]   rdata;
  } regs_t;

  localparam regs_t REGS_RESET = '{
    seq:    SEQ_FETCH,
    loaded: 1'b0,
    lock:   1'b0,
    div:    DIV_RESET,
    sec:    SEC_RESET_VAL,
    idx:    '0,
    rdata:  ZERO_BYTE
  };

  regs_t state_r;
  regs_t state_nxt;

  logic  wr_div;
  logic  wr_idx;
  logic  rd_div;
  logic  rd_sec;
  logic  rd_idx;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Writes to the security offset decode to nothing at all.
  assign wr_div = wr_in && (addr_in == OFS_CLK_DIV);
  assign wr_idx = wr_in && (addr_in == OFS_CMD_IDX);
  assign rd_div = rd_in && (addr_in == OFS_CLK_DIV);
  assign rd_sec = rd_in && (addr_in == OFS_SECURITY);
  assign rd_idx = rd_in && (addr_in == OFS_CMD_IDX);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // The security byte is taken only while the reset sequence is still
  // fetching, so a late load pulse can never overwrite a live value.
  always_comb begin
    state_nxt       = state_r;
    state_nxt.rdata = ZERO_BYTE;

    // Security load sequence after reset release.
    unique case (state_r.seq)
      SEQ_FETCH: begin
        if (sec_load_in) begin
          state_nxt.seq = SEQ_READY;
          if (sec_dbl_fault_in) begin
            state_nxt.sec = SEC_FAULT_VAL;
          end else begin
            state_nxt.sec = sec_byte_in;
          end
        end
      end
      SEQ_READY: begin
        if (backdoor_unsecure_in) begin
          state_nxt.sec[SEC_MSB:SEC_LSB] = SEC_UNSECURED;
        end
      end
      default: begin
        state_nxt.seq = SEQ_FETCH;
      end
    endcase

    // Divider write; the loaded flag follows any write, never the data.
    if (wr_div) begin
      state_nxt.loaded = 1'b1;
      if (special_mode_in) begin
        state_nxt.lock = wdata_in[LOCK_BIT];
        state_nxt.div  = wdata_in[DIV_W-1:0];
      end else if (!state_r.lock) begin
        state_nxt.lock = wdata_in[LOCK_BIT];
        state_nxt.div  = wdata_in[DIV_W-1:0];
      end
      // A locked normal-mode write is dropped silently.
    end

    // Command index write; upper bits have no storage.
    if (wr_idx) begin
      state_nxt.idx = wdata_in[IDX_BITS-1:0];
    end

    // Read data are valid only in the cycle after the read strobe.
    if (rd_div) begin
      state_nxt.rdata = {state_r.loaded, state_r.lock, state_r.div};
    end else if (rd_sec) begin
      state_nxt.rdata = state_r.sec;
    end else if (rd_idx) begin
      state_nxt.rdata = BUS_DW'(state_r.idx);
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= REGS_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------------
  // The tick runs only after software has loaded a divide value; before
  // that the reset value would give a tick at the full bus rate.
  tick_divider #(
    .CNT_W (DIV_W)
  ) u_tick_divider (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .run_in      (state_r.loaded),
    .div_in      (state_r.div),
    .tick_out    (tick_1mhz_out)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // The key and unsecured decodes below come straight from the stored security byte.
  assign rdata_out                = state_r.rdata;
  assign divide_value_out         = state_r.div;
  assign divider_loaded_out       = state_r.loaded;
  assign command_index_out        = state_r.idx;
  assign sec_fetch_req_out        = (state_r.seq == SEQ_FETCH);
  assign backdoor_key_enabled_out =
    (state_r.sec[KEY_MSB:KEY_LSB] == KEY_ENABLED);
  assign unsecured_out            =
    (state_r.sec[SEC_MSB:SEC_LSB] == SEC_UNSECURED);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);

  chk_loaded_on_write: assert property (
    wr_div |=> divider_loaded_out)
    else $error("loaded flag not set after divider write");

  chk_loaded_no_fall: assert property (
    divider_loaded_out |=> divider_loaded_out)
    else $error("loaded flag cleared without reset");

  chk_loaded_only_write: assert property (
    !divider_loaded_out && !wr_div |=> !divider_loaded_out)
    else $error("loaded flag set without a divider write");

  chk_lock_holds_field: assert property (
    wr_div && !special_mode_in && state_r.lock
    |=> $stable(divide_value_out) && state_r.lock)
    else $error("locked divide field changed in normal mode");

  chk_normal_open_write: assert property (
    wr_div && !special_mode_in && !state_r.lock
    |=> divide_value_out == $past(wdata_in[DIV_W-1:0]))
    else $error("open divide field did not take the write");

  chk_special_write: assert property (
    wr_div && special_mode_in
    |=> {state_r.lock, divide_value_out} == $past(wdata_in[LOCK_BIT:0]))
    else $error("special mode write not taken");

  chk_sec_load_byte: assert property (
    sec_fetch_req_out && sec_load_in && !sec_dbl_fault_in
    |=> state_r.sec == $past(sec_byte_in) && !sec_fetch_req_out)
    else $error("security byte not loaded");

  chk_sec_fault_ones: assert property (
    sec_fetch_req_out && sec_load_in && sec_dbl_fault_in
    |=> state_r.sec == SEC_FAULT_VAL && !unsecured_out
        && !backdoor_key_enabled_out)
    else $error("fault load did not secure the part");

  chk_sec_ignores_bus: assert property (
    !sec_fetch_req_out && !backdoor_unsecure_in |=> $stable(state_r.sec))
    else $error("security register changed without a source");

  chk_backdoor_force: assert property (
    !sec_fetch_req_out && backdoor_unsecure_in
    |=> unsecured_out && $stable(state_r.sec[KEY_MSB:SEC_MSB+1]))
    else $error("backdoor unsecure did not force the field");

  chk_idx_readback: assert property (
    rd_idx |=> rdata_out == BUS_DW'($past(command_index_out)))
    else $error("index readback wrong");

  chk_read_one_cycle: assert property (
    !rd_in |=> rdata_out == ZERO_BYTE)
    else $error("read data held past its cycle");

  // ----------------------------------------------------------------------
  // Checks on held state and readback
  // ----------------------------------------------------------------------
  // Each held value may move only on its own strobe or source, so these
  // catch a stray decode that a directed test would never notice.
  // They all stay quiet while the reset is low.

  chk_div_readback: assert property (
    rd_div |=> rdata_out[LOADED_BIT] == $past(divider_loaded_out)
      && rdata_out[LOCK_BIT] == $past(state_r.lock)
      && rdata_out[DIV_W-1:0] == $past(divide_value_out))
    else $error("divider readback wrong");

  chk_sec_readback: assert property (
    rd_sec |=> rdata_out == $past(state_r.sec))
    else $error("security readback wrong");

  // The lock falls only through a special-mode write or a reset.
  chk_lock_sticky: assert property (
    state_r.lock && !(wr_div && special_mode_in) |=> state_r.lock)
    else $error("lock cleared in normal mode");

  chk_div_no_write: assert property (
    !wr_div |=> $stable(divide_value_out))
    else $error("divide field changed without a write");

  chk_idx_write: assert property (
    wr_idx |=> command_index_out == $past(wdata_in[IDX_BITS-1:0]))
    else $error("index write not taken");

  chk_idx_no_write: assert property (
    !wr_idx |=> $stable(command_index_out))
    else $error("index changed without a write");

  // A backdoor event during the fetch must not touch the reset value.
  chk_fetch_holds: assert property (
    sec_fetch_req_out && !sec_load_in
    |=> sec_fetch_req_out && $stable(state_r.sec))
    else $error("security register moved while fetching");

  chk_one_load: assert property (
    !sec_fetch_req_out |=> !sec_fetch_req_out)
    else $error("security fetch restarted without reset");

  chk_tick_needs_load: assert property (
    !divider_loaded_out |=> !tick_1mhz_out)
    else $error("tick before the divider was loaded");

  // Once unsecured after the load, only a reset may secure again.
  chk_unsec_sticky: assert property (
    unsecured_out && !sec_fetch_req_out |=> unsecured_out)
    else $error("part secured again without reset");

  // Main scenarios the bench is expected to reach.
  cov_late_load: cover property (
    !sec_fetch_req_out && sec_load_in);

  cov_lock_then_write: cover property (
    wr_div && state_r.lock && !special_mode_in);

  cov_special_unlock: cover property (
    wr_div && special_mode_in && state_r.lock
    ##1 !state_r.lock);

  cov_fault_load: cover property (
    sec_fetch_req_out && sec_load_in && sec_dbl_fault_in);

  cov_backdoor: cover property (
    !unsecured_out && backdoor_unsecure_in ##1 unsecured_out);

endmodule // flash_regs

// ===== tb/test_flash_regs.sv
// Self-checking testbench for the flash divider, security and index registers.
`timescale 1ns/100ps
module test_flash_regs;
  import flash_regs_pkg::*;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sbyte;
    logic       flt;
    logic [7:0] sreg;
    logic       key;
    logic       unsec;
  } row_t;

  logic              core_clk_in = 1'b0;
  logic              arst_n_in   = 1'b0;
  logic [BUS_AW-1:0] addr_in     = 8'h00;
  logic [BUS_DW-1:0] wdata_in    = 8'h00;
  logic              wr_in = 1'b0, rd_in = 1'b0, special_mode_in = 1'b0;
  logic              sec_load_in = 1'b0, sec_dbl_fault_in = 1'b0;
  logic [7:0]        sec_byte_in = 8'h00;
  logic              backdoor_unsecure_in = 1'b0;
  logic [BUS_DW-1:0] rdata_out;
  logic              sec_fetch_req_out, tick_1mhz_out, divider_loaded_out;
  logic              backdoor_key_enabled_out, unsecured_out;
  logic [DIV_W-1:0]  divide_value_out;
  logic [2:0]        command_index_out;
  int                fails = 0, checks_done = 0, gap;
  row_t              rows [7];

  flash_regs u_flash_regs (
    .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .special_mode_in(special_mode_in),
    .sec_load_in(sec_load_in), .sec_byte_in(sec_byte_in),
    .sec_dbl_fault_in(sec_dbl_fault_in),
    .backdoor_unsecure_in(backdoor_unsecure_in),
    .sec_fetch_req_out(sec_fetch_req_out), .tick_1mhz_out(tick_1mhz_out),
    .divide_value_out(divide_value_out),
    .divider_loaded_out(divider_loaded_out),
    .backdoor_key_enabled_out(backdoor_key_enabled_out),
    .unsecured_out(unsecured_out), .command_index_out(command_index_out)
  );

  // Half-period toggle gives the 200 MHz bus clock.
  always #2.5 core_clk_in = ~core_clk_in;

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Reset is held four clock cycles, released just after an edge.
  task automatic do_reset();
    arst_n_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    @(posedge core_clk_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge core_clk_in);
    wr_in    <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge core_clk_in);
    rd_in   <= 1'b0;
    #1;
    check(rdata_out, exp);
  endtask

  // Write followed by a read at the very next edge, with no idle cycle.
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] exp);
    @(posedge core_clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge core_clk_in);
    wr_in    <= 1'b0;
    rd_in    <= 1'b1;
    @(posedge core_clk_in);
    rd_in    <= 1'b0;
    #1;
    check(rdata_out, exp);
  endtask

  task automatic sec_load(input logic [7:0] b, input logic f);
    @(posedge core_clk_in);
    sec_load_in      <= 1'b1;
    sec_byte_in      <= b;
    sec_dbl_fault_in <= f;
    @(posedge core_clk_in);
    sec_load_in      <= 1'b0;
    #1;
  endtask

  task automatic pulse_backdoor();
    @(posedge core_clk_in);
    backdoor_unsecure_in <= 1'b1;
    @(posedge core_clk_in);
    backdoor_unsecure_in <= 1'b0;
    #1;
  endtask

  // Cycles from one tick to the next; a missing tick gives 100.
  task automatic tick_gap(output int g);
    int n;
    for (n = 0; n < 100 && tick_1mhz_out !== 1'b1; n++) begin
      @(posedge core_clk_in);
      #1;
    end
    g = 0;
    do begin
      @(posedge core_clk_in);
      #1;
      g++;
    end while (tick_1mhz_out !== 1'b1 && g < 100);
  endtask

  // ----------------------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------------------
  initial begin
    #20000;
    fails++;
    results();
  end

  initial begin
    // Security bytes keep reserved bits 5:2 erased (high).
    rows = '{'{8'h3c, 1'b0, 8'h3c, 1'b0, 1'b0},
             '{8'h7d, 1'b0, 8'h7d, 1'b0, 1'b0},
             '{8'hbe, 1'b0, 8'hbe, 1'b1, 1'b1},
             '{8'hff, 1'b0, 8'hff, 1'b0, 1'b0},
             '{8'hbf, 1'b0, 8'hbf, 1'b1, 1'b0},
             '{8'h7e, 1'b0, 8'h7e, 1'b0, 1'b1},
             '{8'hbe, 1'b1, 8'hff, 1'b0, 1'b0}};
    foreach (rows[i]) begin
      do_reset();
      check(sec_fetch_req_out, 8'h01);
      sec_load(rows[i].sbyte, rows[i].flt);
      check(sec_fetch_req_out, 8'h00);
      rd_chk(OFS_SECURITY, rows[i].sreg);
      check(backdoor_key_enabled_out, rows[i].key);
      check(unsecured_out, rows[i].unsec);
    end
    // Reset values, a refused write and a late second load.
    do_reset();
    // A backdoor event while still fetching must leave the reset value.
    pulse_backdoor();
    rd_chk(OFS_CLK_DIV, 8'h00);
    rd_chk(OFS_SECURITY, SEC_RESET_VAL);
    rd_chk(OFS_CMD_IDX, 8'h00);
    sec_load(8'hbd, 1'b0);
    wr(OFS_SECURITY, 8'h00);
    sec_load(8'h3c, 1'b0);
    rd_chk(OFS_SECURITY, 8'hbd);
    check(unsecured_out, 8'h00);
    pulse_backdoor();
    rd_chk(OFS_SECURITY, 8'hbe);
    check(unsecured_out, 8'h01);
    // Index register: only the index bits hold, back to back with a read.
    wr_rd(OFS_CMD_IDX, 8'hff, 8'h07);
    wr_rd(OFS_CMD_IDX, 8'h05, 8'h05);
    check(command_index_out, 8'h05);
    // Unmapped place reads zero and keeps nothing.
    wr(8'h03, 8'ha5);
    rd_chk(8'h03, 8'h00);
    // No tick before the divider is written; then one every div+1 cycles.
    repeat (20) begin
      @(posedge core_clk_in);
      #1;
      check(tick_1mhz_out, 8'h00);
    end
    wr(OFS_CLK_DIV, 8'h02);
    check(divider_loaded_out, 8'h01);
    rd_chk(OFS_CLK_DIV, 8'h82);
    tick_gap(gap);
    check(8'(gap), 8'h03);
    // Lock in normal mode, then a refused write raises nothing.
    wr_rd(OFS_CLK_DIV, 8'h45, 8'hc5);
    wr_rd(OFS_CLK_DIV, 8'h03, 8'hc5);
    check(divide_value_out, 8'h05);
    tick_gap(gap);
    check(8'(gap), 8'h06);
    wr(OFS_CLK_DIV, 8'h00); // Software waits for idle commands.
    rd_chk(OFS_CLK_DIV, 8'hc5);
    // Special mode writes through the lock but never clears bit 7.
    @(posedge core_clk_in);
    special_mode_in <= 1'b1;
    wr_rd(OFS_CLK_DIV, 8'h31, 8'hb1);
    wr_rd(OFS_CLK_DIV, 8'h00, 8'h80);
    @(posedge core_clk_in);
    special_mode_in <= 1'b0;
    // A reset clears lock and loaded flag.
    do_reset();
    rd_chk(OFS_CLK_DIV, 8'h00);
    results();
  end
endmodule // test_flash_regs
